// [design/cprs_params.svh]
/*
 Register offsets, reset values, field positions and timing counts for the
 codec page, reset and sleep register bank. Included by the package user.
*/
`ifndef CPRS_PARAMS_SVH
`define CPRS_PARAMS_SVH

// Register offsets.
`define CPRS_OFS_PAGE    8'h00
`define CPRS_OFS_SWRST   8'h01
`define CPRS_OFS_REFCFG  8'h02
`define CPRS_OFS_SUPSTS  8'h03
`define CPRS_OFS_DAC1BA  8'h69
`define CPRS_OFS_DAC1BB  8'h6A
`define CPRS_OFS_OUT2A   8'h6B
`define CPRS_OFS_OUT2B   8'h6C
`define CPRS_OFS_OUT2C   8'h6D
`define CPRS_OFS_DAC2AA  8'h6E
`define CPRS_OFS_DAC2AB  8'h6F
`define CPRS_OFS_DAC2BA  8'h70
`define CPRS_OFS_DAC2BB  8'h71
`define CPRS_OFS_DSPA    8'h72
`define CPRS_OFS_DSPB    8'h73
`define CPRS_OFS_CHEN    8'h76
`define CPRS_OFS_DYNPU   8'h77
`define CPRS_OFS_PWR     8'h78
`define CPRS_OFS_STS1    8'h79
`define CPRS_OFS_STS2    8'h7A
`define CPRS_OFS_CKSUM   8'h7E

// Reset values.
`define CPRS_RST_ZERO    8'h00
`define CPRS_RST_DACA    8'hC9
`define CPRS_RST_DACB    8'h80
`define CPRS_RST_OUT     8'h20
`define CPRS_RST_DSP     8'h18
`define CPRS_RST_CHEN    8'hCC
`define CPRS_RST_STS2    8'h80

// Writable masks and field positions.
`define CPRS_MASK_REFCFG 8'h3F
`define CPRS_BIT_SWRST   0
`define CPRS_BIT_AWAKE   0
`define CPRS_BIT_IORANGE 1
`define CPRS_BIT_ASUP    2
`define CPRS_BIT_WAKEREF 3
`define CPRS_FLD_QCHG_LO 4
`define CPRS_BIT_AOVR    7
`define CPRS_BIT_IOOVR   6

// Quick-charge durations in microseconds, then cycles at 100 MHz.
`define CPRS_CLK_MHZ     100
`define CPRS_QCHG0_US    3500
`define CPRS_QCHG1_US    10000
`define CPRS_QCHG2_US    50000
`define CPRS_QCHG3_US    100000
`define CPRS_QCHG0_CYC   (`CPRS_QCHG0_US * `CPRS_CLK_MHZ)
`define CPRS_QCHG1_CYC   (`CPRS_QCHG1_US * `CPRS_CLK_MHZ)
`define CPRS_QCHG2_CYC   (`CPRS_QCHG2_US * `CPRS_CLK_MHZ)
`define CPRS_QCHG3_CYC   (`CPRS_QCHG3_US * `CPRS_CLK_MHZ)

`endif

// [design/cprs_pkg.sv]
/*
 Types shared by the codec page, reset and sleep register bank.
 Assumes cprs_params.svh is on the include path.
*/
package cprs_pkg;
   // Number of stored page-0 configuration bytes at the top of the map.
   localparam int CFG_COUNT = 15;

   typedef logic [7:0] cprs_byte_t;

   typedef enum logic [1:0] {
      CPRS_SLEEP,
      CPRS_CHARGE,
      CPRS_AWAKE
   } cprs_state_t;

   typedef struct packed {
      cprs_byte_t                 page;
      logic [5:0]                 refCfg;
      cprs_byte_t [CFG_COUNT-1:0] cfg;
      logic                       readValid;
      cprs_state_t                state;
      logic [23:0]                chargeCount;
      logic                       analogOverride;
      logic                       ioOverride;
      cprs_byte_t                 readData;
   } cprs_regs_t;
endpackage

// [design/cprs_reg_bank.sv]
/*
 Page, software reset and reference/sleep register bank of an audio codec,
 with the stored default entries at the top of page 0.
 Assumes an I2C target in front of it that turns bus transactions into one
 cycle write and read strobes with an 8-bit offset, synchronous to mclk.
 The supply comparators arrive as levels synchronous to mclk.
 Only one strobe is expected per cycle; a read and a write together are
 both honoured, the read returning the value from before the write,
 unless the write fires the software reset, which drops the read.
 Pages other than zero hold no storage here: writes to them are dropped
 and reads return zero, apart from the page selector itself.
 Quick-charge lengths are counted in mclk cycles, so they are only right
 while mclk runs at the rate the timing counts were built for.
 Status bytes one and two report fixed values; the blocks they describe lie outside.
 The supply override flags are read back on page zero next to the
 reference configuration, one cycle behind their comparators.
*/
// Notes on behaviour
// - Offset zero holds eight-bit read/write page selector.
// - Page selector reads zero after any reset.
// - Writing one to reset bit restores all defaults.
// - Bits 5-4 pick reference quick-charge duration.
// - Bit 3 picks what wakes on sleep exit.
// - Bit 2 selects analog supply mode.
// - Bit 1 selects I/O supply range.
// - Bit 0 low keeps device asleep.
// - Channel enable register resets to 0xCC.
// - Status two reads 0x80, status one zero.
// - High analog supply forces mode zero, flags.
// - High I/O supply forces mode zero, flags.
`timescale 1ns/1ns
`default_nettype none
`include "cprs_params.svh"

module cprs_reg_bank (
   // Clock and reset.
   input  wire logic              mclk,
   input  wire logic              srst,
   // Register port from the control interface.
   input  wire logic              regWrite,
   input  wire logic              regRead,
   input  wire logic [7:0]        regAddr,
   input  wire cprs_pkg::cprs_byte_t regWdata,
   output logic                   regRvalid,
   output cprs_pkg::cprs_byte_t   regRdata,
   // Supply comparators.
   input  wire logic              analogSupplyHigh,
   input  wire logic              ioSupplyHigh,
   // Power control outputs, page selector and channel enables.
   output logic                   awakeControlN,
   output logic                   digitalCoreRegulatorOn,
   output logic                   voltageReferenceOn,
   output logic                   referenceFastCharge,
   output logic                   analogSupplySelect,
   output logic                   ioSupplyRange,
   output cprs_pkg::cprs_byte_t   pageSelect,
   output cprs_pkg::cprs_byte_t   channelEnables
);
   import cprs_pkg::*;

   // Offsets of the stored configuration bytes in map order; an entry's index
   // is the index of its byte in the state struct.
   localparam cprs_byte_t CFG_OFS [CFG_COUNT] = '{
      `CPRS_OFS_DAC1BA,
      `CPRS_OFS_DAC1BB,
      `CPRS_OFS_OUT2A,
      `CPRS_OFS_OUT2B,
      `CPRS_OFS_OUT2C,
      `CPRS_OFS_DAC2AA,
      `CPRS_OFS_DAC2AB,
      `CPRS_OFS_DAC2BA,
      `CPRS_OFS_DAC2BB,
      `CPRS_OFS_DSPA,
      `CPRS_OFS_DSPB,
      `CPRS_OFS_CHEN,
      `CPRS_OFS_DYNPU,
      `CPRS_OFS_PWR,
      `CPRS_OFS_CKSUM};
   // Reset values in the same order.
   localparam cprs_byte_t CFG_RST [CFG_COUNT] = '{
      `CPRS_RST_DACA,
      `CPRS_RST_DACB,
      `CPRS_RST_OUT,
      `CPRS_RST_OUT,
      `CPRS_RST_OUT,
      `CPRS_RST_DACA,
      `CPRS_RST_DACB,
      `CPRS_RST_DACA,
      `CPRS_RST_DACB,
      `CPRS_RST_DSP,
      `CPRS_RST_DSP,
      `CPRS_RST_CHEN,
      `CPRS_RST_ZERO,
      `CPRS_RST_ZERO,
      `CPRS_RST_ZERO};
   // Channel enables also leave the bank as a port of their own.
   localparam int CHEN_IDX  = 11;

   // All state of the bank lives in one struct; next_regs is its next value.
   cprs_regs_t regs;
   cprs_regs_t next_regs;

   // Reset image shared by srst and the software reset bit.
   // Everything not named here, read data and the counter included, is zero.
   function automatic cprs_regs_t resetImage();
      cprs_regs_t r;
      r                = '0;
      r.page           = `CPRS_RST_ZERO;
      r.state          = CPRS_SLEEP;
      for (int i = 0; i < CFG_COUNT; i++) begin
         r.cfg[i] = CFG_RST[i];
      end
      return r;
   endfunction

   // Offset match used by both the write and the read decode.
   function automatic logic hitAt(input logic [7:0] a, input cprs_byte_t ofs);
      return a == ofs;
   endfunction

   // Quick-charge length in cycles for a duration code.
   // The longest count fills most of 24 bits; a faster mclk needs a wider one.
   function automatic logic [23:0] chargeCycles(input logic [1:0] code);
      case (code)
         2'd0:    return 24'(`CPRS_QCHG0_CYC);
         2'd1:    return 24'(`CPRS_QCHG1_CYC);
         2'd2:    return 24'(`CPRS_QCHG2_CYC);
         default: return 24'(`CPRS_QCHG3_CYC);
      endcase
   endfunction

   // Mode bits as the host should see them while a supply comparator is high.
   // The stored copy is left alone, so the host's own setting comes back by
   // itself once the supply drops again.
   function automatic logic [5:0] forcedRefCfg(input logic [5:0] cfg,
                                               input logic       aHigh,
                                               input logic       ioHigh);
      logic [5:0] f;
      f = cfg;
      if (aHigh) begin
         f[`CPRS_BIT_ASUP] = 1'b0;
      end
      if (ioHigh) begin
         f[`CPRS_BIT_IORANGE] = 1'b0;
      end
      return f;
   endfunction

   logic                 onPageZero;
   logic                 softReset;
   logic [5:0]           refEffective;
   logic [CFG_COUNT-1:0] cfgHit;

   // Offset zero is decoded on every page so the host can always leave;
   // everything else is decoded on page zero only.
   assign onPageZero   = (regs.page == 8'h00);
   assign softReset    = regWrite && onPageZero && hitAt(regAddr, `CPRS_OFS_SWRST)
                         && regWdata[`CPRS_BIT_SWRST];
   assign refEffective = forcedRefCfg(regs.refCfg, analogSupplyHigh, ioSupplyHigh);

   // One hit line per stored byte, shared by the write and the read decode.
   // The stored bytes have no side effects, so a hit is all either needs.
   for (genvar i = 0; i < CFG_COUNT; i++) begin : g_cfg_hit
      assign cfgHit[i] = onPageZero && hitAt(regAddr, CFG_OFS[i]);
   end

   // Next-state logic for the whole bank.
   always_comb begin
      next_regs = regs;
      // The read answer is a one-cycle pulse; the read data itself holds.
      next_regs.readValid      = regRead;
      next_regs.analogOverride = analogSupplyHigh;
      next_regs.ioOverride     = ioSupplyHigh;

      // Register writes; reserved bits are masked off on the way in. A write
      // to the reset register stores nothing: its bit only fires the reset.
      if (regWrite) begin
         // The page selector answers on every page, so no page strands the host.
         if (hitAt(regAddr, `CPRS_OFS_PAGE)) begin
            next_regs.page = regWdata;
         end
         if (onPageZero && hitAt(regAddr, `CPRS_OFS_REFCFG)) begin
            next_regs.refCfg = 6'(regWdata & `CPRS_MASK_REFCFG);
         end
         for (int i = 0; i < CFG_COUNT; i++) begin
            if (cfgHit[i]) begin
               next_regs.cfg[i] = regWdata;
            end
         end
      end

      // Sleep and reference quick-charge sequencing. Clearing the awake bit
      // ends a charge at once; a charge cut short starts from the full count
      // on the next wake, since the capacitor state is not known here.
      case (regs.state)
         CPRS_SLEEP: begin
            // Holding the counter at zero keeps a stale count out of a wake.
            next_regs.chargeCount = '0;
            if (regs.refCfg[`CPRS_BIT_AWAKE]) begin
               if (regs.refCfg[`CPRS_BIT_WAKEREF]) begin
                  next_regs.state       = CPRS_CHARGE;
                  next_regs.chargeCount =
                     chargeCycles(regs.refCfg[5:4]);
               end else begin
                  next_regs.state = CPRS_AWAKE;
               end
            end
         end
         CPRS_CHARGE: begin
            // The count is loaded on entry, so it never starts at zero here.
            if (!regs.refCfg[`CPRS_BIT_AWAKE]) begin
               next_regs.state = CPRS_SLEEP;
            end else if (regs.chargeCount <= 24'h00_0001) begin
               next_regs.state       = CPRS_AWAKE;
               next_regs.chargeCount = '0;
            end else begin
               next_regs.chargeCount = regs.chargeCount - 24'h00_0001;
            end
         end
         CPRS_AWAKE: begin
            // Mode bits may change freely here; only the awake bit ends it.
            if (!regs.refCfg[`CPRS_BIT_AWAKE]) begin
               next_regs.state = CPRS_SLEEP;
            end
         end
         default: begin
            // An unknown state code falls back to sleep, the safe state.
            next_regs.state = CPRS_SLEEP;
         end
      endcase

      // Read mux; unmapped offsets and, but for the page selector, other pages read zero. The data comes
      // from the registered state, bar the live comparators masking the reference byte, so a write in the same cycle is not seen.
      if (regRead) begin
         next_regs.readData = 8'h00;
         if (hitAt(regAddr, `CPRS_OFS_PAGE)) begin
            next_regs.readData = regs.page;
         end else if (onPageZero) begin
            // The reset bit clears itself, so it always reads back as zero.
            if (hitAt(regAddr, `CPRS_OFS_SWRST)) begin
               next_regs.readData = 8'h00;
            end else if (hitAt(regAddr, `CPRS_OFS_REFCFG)) begin
               next_regs.readData = {2'b00, refEffective};
            end else if (hitAt(regAddr, `CPRS_OFS_SUPSTS)) begin
               next_regs.readData = {regs.analogOverride, regs.ioOverride,
                                     6'h00};
            end else if (hitAt(regAddr, `CPRS_OFS_STS1)) begin
               next_regs.readData = 8'h00;
            end else if (hitAt(regAddr, `CPRS_OFS_STS2)) begin
               next_regs.readData = `CPRS_RST_STS2;
            end else begin
               for (int i = 0; i < CFG_COUNT; i++) begin
                  if (cfgHit[i]) begin
                     next_regs.readData = regs.cfg[i];
                  end
               end
            end
         end
      end

      // Software reset wins over everything else in the same cycle. A read
      // in that cycle is dropped rather than answered with stale data.
      if (softReset) begin
         next_regs = resetImage();
      end
   end

   // State register. The reset image is the one the software reset loads,
   // so both kinds of reset leave the bank in exactly the same state.
   always_ff @(posedge mclk) begin
      if (srst) begin
         regs <= resetImage();
      end else begin
         regs <= next_regs;
      end
   end

   // Outputs, all from flip-flops; the read answer comes one cycle after
   // its strobe.
   assign regRvalid              = regs.readValid;
   assign regRdata               = regs.readData;
   assign pageSelect             = regs.page;
   assign channelEnables         = regs.cfg[CHEN_IDX];
   assign awakeControlN          = regs.refCfg[`CPRS_BIT_AWAKE];

   // Core regulator, reference and fast-charge controls follow the sequencer state, so a
   // wake with the reference enabled always passes through the charge state; the supply selects follow their bits, held low by the registered overrides.
   assign digitalCoreRegulatorOn = (regs.state != CPRS_SLEEP);
   assign voltageReferenceOn     = (regs.state != CPRS_SLEEP)
                                   && regs.refCfg[`CPRS_BIT_WAKEREF];
   assign referenceFastCharge    = (regs.state == CPRS_CHARGE);
   assign analogSupplySelect     = regs.refCfg[`CPRS_BIT_ASUP]
                                   && !regs.analogOverride;
   assign ioSupplyRange          = regs.refCfg[`CPRS_BIT_IORANGE]
                                   && !regs.ioOverride;
endmodule

`default_nettype wire

// [tb/cprs_reg_bank_checker.sv]
/*
 Port assertions for the register bank.
 Bound into cprs_reg_bank; needs cprs_pkg compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module cprs_reg_bank_checker (
   // Clock, reset and register port.
   input wire logic                 mclk,
   input wire logic                 srst,
   input wire logic                 regWrite,
   input wire logic                 regRead,
   input wire logic [7:0]           regAddr,
   input wire cprs_pkg::cprs_byte_t regWdata,
   input wire logic                 regRvalid,
   // Supplies, power controls, page selector and channel enables.
   input wire logic                 analogSupplyHigh,
   input wire logic                 ioSupplyHigh,
   input wire logic                 awakeControlN,
   input wire logic                 digitalCoreRegulatorOn,
   input wire logic                 analogSupplySelect,
   input wire logic                 ioSupplyRange,
   input wire cprs_pkg::cprs_byte_t pageSelect,
   input wire cprs_pkg::cprs_byte_t channelEnables
);
   import cprs_pkg::*;
   // One clock domain, so clocking and reset are given once.
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   a_read_answer: assert property (
      regRead && !regWrite |=> regRvalid) else $error("read not answered");
   a_page_write: assert property (
      regWrite && regAddr == 8'h00 |=> pageSelect == $past(regWdata))
      else $error("page write lost");
   a_soft_reset: assert property (
      regWrite && pageSelect == 8'h00 && regAddr == 8'h01 && regWdata[0]
      |=> pageSelect == 8'h00 && channelEnables == 8'hCC && !awakeControlN)
      else $error("soft reset left state");
   a_awake_follows: assert property (
      regWrite && pageSelect == 8'h00 && regAddr == 8'h02
      |=> {7'h00, awakeControlN} == ($past(regWdata) & 8'h01))
      else $error("awake control not stored");
   // The core regulator may trail the sleep bit by a cycle or two.
   a_core_sleep: assert property (
      !awakeControlN [*3] |-> !digitalCoreRegulatorOn)
      else $error("core on while asleep");
   a_core_wake: assert property (
      $rose(awakeControlN) |-> ##[1:2] digitalCoreRegulatorOn)
      else $error("core not woken");
   a_analog_forced: assert property (
      analogSupplyHigh [*3] |-> !analogSupplySelect)
      else $error("analog mode not forced");
   a_io_forced: assert property (
      ioSupplyHigh [*3] |-> !ioSupplyRange) else $error("io mode not forced");
endmodule
bind cprs_reg_bank cprs_reg_bank_checker chk_u (
   .mclk, .srst, .regWrite, .regRead, .regAddr, .regWdata, .regRvalid,
   .analogSupplyHigh, .ioSupplyHigh, .awakeControlN, .digitalCoreRegulatorOn,
   .analogSupplySelect, .ioSupplyRange, .pageSelect, .channelEnables);
`default_nettype wire

// [tb/cprs_host_model.sv]
/*
 Control-port host issuing one-cycle register strobes.
 Assumes a free-running mclk from the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module cprs_host_model (
   // Clock and answer from the bank.
   input  wire logic                 mclk,
   input  wire logic                 regRvalid,
   input  wire cprs_pkg::cprs_byte_t regRdata,
   // Requests toward the bank.
   output var logic                  regWrite,
   output var logic                  regRead,
   output var logic [7:0]            regAddr,
   output var cprs_pkg::cprs_byte_t  regWdata
);
   import cprs_pkg::*;
   // Idle bus at time zero.
   initial begin
      regWrite = 1'b0;
      regRead = 1'b0;
      regAddr = 8'hFF;
      regWdata = 8'hFF;
   end
   // Released lines show the inverse so stale values never pass.
   task automatic wr(input cprs_byte_t a, input cprs_byte_t d);
      @(posedge mclk);
      #1;
      regWrite = 1'b1;
      regAddr = a;
      regWdata = (a == 8'h01) ? (d & 8'h01) : (a == 8'h02) ? (d & 8'h3F) : d;
      @(posedge mclk);
      #1;
      regWrite = 1'b0;
      regAddr = ~a;
      regWdata = ~regWdata;
   endtask
   // The answer is taken one cycle after the read edge.
   task automatic rd(input cprs_byte_t a, output logic v, output cprs_byte_t d);
      @(posedge mclk);
      #1;
      regRead = 1'b1;
      regAddr = a;
      @(posedge mclk);
      #1;
      regRead = 1'b0;
      regAddr = ~a;
      v = regRvalid;
      d = regRdata;
   endtask
endmodule
`default_nettype wire

// [tb/cprs_reg_bank_tb.sv]
/*
 Self-checking bench for the page, reset and sleep register bank.
 Assumes the design, checker and host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module cprs_reg_bank_tb;
   import cprs_pkg::*;
   logic       mclk, srst, regWrite, regRead, regRvalid, v;
   logic       analogSupplyHigh, ioSupplyHigh, awakeControlN, digitalCoreRegulatorOn;
   logic       voltageReferenceOn, referenceFastCharge, analogSupplySelect, ioSupplyRange;
   logic [7:0] regAddr;
   cprs_byte_t regWdata, regRdata, pageSelect, channelEnables, d;
   int         fails, nCompared;
   localparam logic [159:0] ADDRS = {8'h00, 8'h01, 8'h02, 8'h69, 8'h6A, 8'h6B, 8'h6C,
      8'h6D, 8'h6E, 8'h6F, 8'h70, 8'h71, 8'h72, 8'h73, 8'h76, 8'h77, 8'h78, 8'h79, 8'h7A, 8'h7E};
   localparam logic [159:0] DEFS = {8'h00, 8'h00, 8'h00, 8'hC9, 8'h80, 8'h20, 8'h20,
      8'h20, 8'hC9, 8'h80, 8'hC9, 8'h80, 8'h18, 8'h18, 8'hCC, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00};
   cprs_reg_bank dut_u (.mclk, .srst, .regWrite, .regRead, .regAddr, .regWdata, .regRvalid,
      .regRdata, .analogSupplyHigh, .ioSupplyHigh, .awakeControlN, .digitalCoreRegulatorOn,
      .voltageReferenceOn, .referenceFastCharge, .analogSupplySelect, .ioSupplyRange,
      .pageSelect, .channelEnables);
   cprs_host_model host_u (.mclk, .regRvalid, .regRdata, .regWrite, .regRead, .regAddr,
      .regWdata);
   // Free-running 100 MHz clock.
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;
   function automatic cprs_byte_t ad(int i); return ADDRS[8*(19-i) +: 8]; endfunction
   function automatic cprs_byte_t df(int i); return DEFS[8*(19-i) +: 8]; endfunction
   task automatic cmp8(input string n, input cprs_byte_t e, input cprs_byte_t g);
      nCompared++;
      if (g !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cmp1(input string n, input logic e, input logic g);
      cmp8(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic rdc(input cprs_byte_t a, input cprs_byte_t e);
      host_u.rd(a, v, d);
      cmp1("regRvalid", 1'b1, v);
      cmp8("regRdata", e, d);
   endtask
   task automatic chkDefaults;
      for (int i = 0; i < 20; i++) rdc(ad(i), df(i));
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic completeRun;
      if (fails == 0 && nCompared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // A hang is cut short well beyond the few hundred cycles the run needs.
   initial begin
      #200000;
      fails++;
      completeRun();
   end
   // Main sequence; status bytes keep their values when written.
   initial begin
      srst = 1'b1;
      analogSupplyHigh = 1'b0;
      ioSupplyHigh = 1'b0;
      fails = 0;
      nCompared = 0;
      tick(2);
      srst = 1'b0;
      chkDefaults();
      for (int i = 3; i < 20; i++) begin
         host_u.wr(ad(i), ~df(i));
         rdc(ad(i), (i == 17 || i == 18) ? df(i) : ~df(i));
      end
      host_u.wr(8'h00, 8'hFF);
      cmp8("pageSelect", 8'hFF, pageSelect);
      host_u.wr(8'h76, 8'hCC);
      rdc(8'h76, 8'h00);
      rdc(8'h00, 8'hFF);
      host_u.wr(8'h00, 8'h00);
      host_u.wr(8'h01, 8'h00);
      rdc(8'h76, 8'h33);
      cmp8("channelEnables", 8'h33, channelEnables);
      host_u.wr(8'h02, 8'h01);
      cmp1("awakeControlN", 1'b1, awakeControlN);
      tick(1);
      cmp1("digitalCoreRegulatorOn", 1'b1, digitalCoreRegulatorOn);
      cmp1("voltageReferenceOn", 1'b0, voltageReferenceOn);
      host_u.wr(8'h02, 8'h00);
      tick(3);
      cmp1("digitalCoreRegulatorOn", 1'b0, digitalCoreRegulatorOn);
      host_u.wr(8'h02, 8'h09);
      tick(1);
      cmp1("referenceFastCharge", 1'b1, referenceFastCharge);
      cmp1("voltageReferenceOn", 1'b1, voltageReferenceOn);
      host_u.wr(8'h02, 8'h00);
      tick(2);
      cmp1("referenceFastCharge", 1'b0, referenceFastCharge);
      for (int q = 0; q < 4; q++) begin
         host_u.wr(8'h02, {2'b00, q[1:0], 4'h6});
         rdc(8'h02, {2'b00, q[1:0], 4'h6});
      end
      cmp1("analogSupplySelect", 1'b1, analogSupplySelect);
      cmp1("ioSupplyRange", 1'b1, ioSupplyRange);
      analogSupplyHigh = 1'b1;
      tick(3);
      cmp1("analogSupplySelect", 1'b0, analogSupplySelect);
      rdc(8'h03, 8'h80);
      ioSupplyHigh = 1'b1;
      tick(3);
      cmp1("ioSupplyRange", 1'b0, ioSupplyRange);
      rdc(8'h03, 8'hC0);
      rdc(8'h02, 8'h30);
      analogSupplyHigh = 1'b0;
      ioSupplyHigh = 1'b0;
      tick(3);
      rdc(8'h02, 8'h36);
      host_u.wr(8'h01, 8'h01);
      chkDefaults();
      cmp8("channelEnables", 8'hCC, channelEnables);
      host_u.wr(8'h74, 8'h5A);
      rdc(8'h74, 8'h00);
      // Reset again in mid-run, with the bank awake and on another page.
      host_u.wr(8'h02, 8'h01);
      host_u.wr(8'h00, 8'h05);
      srst = 1'b1;
      tick(2);
      srst = 1'b0;
      cmp8("pageSelect", 8'h00, pageSelect);
      cmp1("awakeControlN", 1'b0, awakeControlN);
      rdc(8'h02, 8'h00);
      completeRun();
   end
endmodule
`default_nettype wire
